/* File: vipc_map.svh */
`ifndef VIPC_MAP_SVH
`define VIPC_MAP_SVH
// Function
// - User vector number equals request number plus eight, up to request 71.
// - Primary entries two bytes apart; alternate entry sits 0x100 higher.
// - Eight trap vectors from 0x000004 (alternate 0x000104), five named sources.
// - Thirty-four registers: two control, five flag, five enable, eighteen priority, one pending, status, core control, trap request.
// - Control A holds nesting disable; trap status flags sit in the trap request word.
// - Control B holds the alternate table select in bit 15.
// - Request flags set by hardware, cleared only by software write.
// - Each user source has its own independent enable bit.
// - Each user source gets a 3-bit priority, eight levels.
// - Pending register latches 7-bit vector number and 4-bit level.
// - Latched level equals priority of a pending user source, 15 for a trap.
// - Flag, enable and priority positions follow request number order.
// - Ties resolve by natural order, request 0 first.
// - Status word bits 7:5 show and set the CPU level field.
// - Level top bit in core control word is read-only to software.
// - Level is top bit joined with field; 7 or top bit masks users.
// - Level field read-only while nesting is disabled.
// - Alternate select bit 15 moves every vector fetch to alternate table.
// - Nesting disable blocks taking an interrupt while one is in service.

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define VIPC_OFF_CTRL_A    12'h000
`define VIPC_OFF_CTRL_B    12'h004
`define VIPC_OFF_FLAG0     12'h008
`define VIPC_OFF_EN0       12'h01c
`define VIPC_OFF_PRIO0     12'h030
`define VIPC_OFF_PENDING   12'h078
`define VIPC_OFF_STATUS    12'h07c
`define VIPC_OFF_CORECTL   12'h080
`define VIPC_OFF_TRAPREQ   12'h084

// ----------------------------------------
// Fields and vector layout
// ----------------------------------------
`define VIPC_NEST_DIS_BIT  15
`define VIPC_ALT_SEL_BIT   15
`define VIPC_LVL_LSB       5
`define VIPC_TOP_BIT       3
`define VIPC_VEC_OFFSET    7'h08
`define VIPC_TRAP_BASE     24'h000004
`define VIPC_ALT_DELTA     24'h000100
`define VIPC_CTRL_A_MASK   16'hfffe
`define VIPC_RESET_WORD    16'h0000
`endif

/* File: vipc_pkg.sv */
package vipc_pkg;
    typedef logic [3:0] vipc_level_t;
    typedef logic [6:0] vipc_vec_t;
    typedef enum logic [1:0] {VIPC_IDLE, VIPC_PRESENT, VIPC_SERVICE} vipc_state_t;
endpackage

/* File: vipc_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Priority pick among user sources
// ----------------------------------------
module vipc_arbiter #(
    parameter int N = 72
) (
    input  wire logic [N-1:0]   i_req,
    input  wire logic [3*N-1:0] i_prio,
    input  wire vipc_pkg::vipc_level_t i_cpu_level,
    output logic                o_valid,
    output logic [6:0]          o_idx,
    output logic [2:0]          o_prio
);
    import vipc_pkg::*;
    // Scan from top so lowest request wins ties
    always_comb begin
        o_valid = 1'b0;
        o_idx   = 7'h00;
        o_prio  = 3'h0;
        for (int k = N - 1; k >= 0; k--) begin
            if (i_req[k] && ({1'b0, i_prio[3*k +: 3]} > i_cpu_level) &&
                (!o_valid || i_prio[3*k +: 3] >= o_prio)) begin
                o_valid = 1'b1;
                o_idx   = 7'(k);
                o_prio  = i_prio[3*k +: 3];
            end
        end
    end
endmodule
`default_nettype wire

/* File: vipc_addr.sv */
`timescale 1ns/10ps
`default_nettype none
`include "vipc_map.svh"
// ----------------------------------------
// Vector number to table address
// ----------------------------------------
module vipc_addr (
    input  wire logic [6:0] i_vec,
    input  wire logic       i_alt,
    output logic [23:0]     o_addr
);
    // Two bytes per entry; alternate table above primary
    always_comb begin
        o_addr = `VIPC_TRAP_BASE + {16'h0000, i_vec, 1'b0};
        if (i_alt) begin
            o_addr = o_addr + `VIPC_ALT_DELTA;
        end
    end
endmodule
`default_nettype wire

/* File: vipc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "vipc_map.svh"
module vipc_top #(
    parameter int N_SRC = 72
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST_B,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [71:0] i_src_event,
    input  wire logic [7:0]  i_trap_event,
    input  wire logic        i_irq_ack,
    input  wire logic        i_irq_return,
    output logic             o_irq_req,
    output logic [6:0]       o_vec_num,
    output logic [23:0]      o_vec_addr,
    output vipc_pkg::vipc_level_t o_cpu_level
);
    import vipc_pkg::*;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [15:0]       ctrl_a;
    logic [15:0]       ctrl_b;
    logic [79:0]       flags;
    logic [79:0]       enables;
    logic [287:0]      prios;
    logic [2:0]        lvl_field;
    logic              lvl_top;
    logic [7:0]        trap_pend;
    vipc_vec_t         pend_vec;
    vipc_level_t       pend_lvl;
    vipc_state_t       state;
    logic              arb_valid;
    logic [6:0]        arb_idx;
    logic [2:0]        arb_prio;
    logic [6:0]        sel_vec;
    logic              trap_any;
    logic [2:0]        trap_idx;
    logic              wr;
    logic              hit;
    logic [4:0]        word;
    vipc_level_t       cpu_level;
    logic [N_SRC-1:0]  active;
    logic [3*N_SRC-1:0] prio_flat;

    assign wr = i_psel && i_penable && i_pwrite;
    assign word = i_paddr[6:2];
    assign o_pready = 1'b1;
    assign cpu_level = {lvl_top, lvl_field};
    assign o_cpu_level = cpu_level;
    assign active = flags[N_SRC-1:0] & enables[N_SRC-1:0];

    // Unpack priority words: four sources per word, one 3-bit field per nibble
    always_comb begin
        prio_flat = '0;
        for (int s = 0; s < N_SRC; s++) begin
            prio_flat[3*s +: 3] = prios[16*(s/4) + 4*(s%4) +: 3];
        end
    end

    // Address in a banked range
    function automatic logic in_range(input logic [11:0] a, input logic [11:0] base,
                                      input int cnt);
        in_range = (a >= base) && (a < base + 12'(cnt * 4));
    endfunction

    // ----------------------------------------
    // Arbitration and vector address
    // ----------------------------------------
    vipc_arbiter #(.N(N_SRC)) u_arb (
        .i_req       (active),
        .i_prio      (prio_flat),
        .i_cpu_level (cpu_level),
        .o_valid     (arb_valid),
        .o_idx       (arb_idx),
        .o_prio      (arb_prio)
    );

    // Lowest pending trap number wins; traps ignore level masking
    always_comb begin
        trap_any = 1'b0;
        trap_idx = 3'h0;
        for (int t = 7; t >= 0; t--) begin
            if (trap_pend[t]) begin
                trap_any = 1'b1;
                trap_idx = 3'(t);
            end
        end
    end

    assign sel_vec = trap_any ? {4'h0, trap_idx} : arb_idx + `VIPC_VEC_OFFSET;

    vipc_addr u_addr (
        .i_vec  (pend_vec),
        .i_alt  (ctrl_b[`VIPC_ALT_SEL_BIT]),
        .o_addr (o_vec_addr)
    );

    // ----------------------------------------
    // Presentation state machine
    // ----------------------------------------
    // Hold the latched vector steady until the core acknowledges
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            state    <= VIPC_IDLE;
            pend_vec <= 7'h00;
            pend_lvl <= 4'h0;
        end else begin
            case (state)
                VIPC_IDLE: begin
                    if (trap_any) begin
                        state    <= VIPC_PRESENT;
                        pend_vec <= sel_vec;
                        pend_lvl <= 4'hf;
                    end else if (arb_valid && !lvl_top) begin
                        state    <= VIPC_PRESENT;
                        pend_vec <= sel_vec;
                        pend_lvl <= {1'b0, arb_prio};
                    end
                end
                VIPC_PRESENT: begin
                    if (i_irq_ack) begin
                        state <= VIPC_SERVICE;
                    end
                end
                VIPC_SERVICE: begin
                    if (i_irq_return) begin
                        state <= VIPC_IDLE;
                    end else if (!ctrl_a[`VIPC_NEST_DIS_BIT] && arb_valid
                                 && !lvl_top) begin
                        state    <= VIPC_PRESENT;
                        pend_vec <= sel_vec;
                        pend_lvl <= {1'b0, arb_prio};
                    end
                end
                default: state <= VIPC_IDLE;
            endcase
        end
    end

    assign o_irq_req = (state == VIPC_PRESENT);
    assign o_vec_num = pend_vec;

    // ----------------------------------------
    // CPU level: core raises it on ack, software writes field
    // ----------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            lvl_field <= 3'h0;
            lvl_top   <= 1'b0;
        end else if (state == VIPC_PRESENT && i_irq_ack) begin
            lvl_field <= pend_lvl[2:0];
            lvl_top   <= pend_lvl[3];
        end else if (state == VIPC_SERVICE && i_irq_return) begin
            lvl_field <= 3'h0;
            lvl_top   <= 1'b0;
        end else if (wr && i_paddr == `VIPC_OFF_STATUS
                     && !ctrl_a[`VIPC_NEST_DIS_BIT]) begin
            lvl_field <= i_pwdata[`VIPC_LVL_LSB +: 3];
        end
        // Top bit has no software write path
    end

    // ----------------------------------------
    // Request flags: set wins over software clear
    // ----------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            flags <= 80'h0;
        end else begin
            for (int r = 0; r < 5; r++) begin
                if (wr && i_paddr == `VIPC_OFF_FLAG0 + 12'(r * 4)) begin
                    flags[16*r +: 16] <= i_pwdata[15:0] & flags[16*r +: 16];
                end
            end
            for (int s = 0; s < N_SRC; s++) begin
                if (i_src_event[s]) begin
                    flags[s] <= 1'b1;
                end
            end
        end
    end

    // Trap status: hardware sets, cleared when the core takes the trap vector
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            trap_pend <= 8'h00;
        end else begin
            if (state == VIPC_PRESENT && i_irq_ack && pend_lvl == 4'hf) begin
                trap_pend[pend_vec[2:0]] <= 1'b0;
            end
            for (int t = 1; t < 6; t++) begin
                if (i_trap_event[t]) begin
                    trap_pend[t] <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Control, enable and priority writes
    // ----------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            ctrl_a  <= `VIPC_RESET_WORD;
            ctrl_b  <= `VIPC_RESET_WORD;
            enables <= 80'h0;
            prios   <= 288'h0;
        end else if (wr) begin
            if (i_paddr == `VIPC_OFF_CTRL_A) begin
                ctrl_a <= i_pwdata[15:0] & `VIPC_CTRL_A_MASK;
            end
            if (i_paddr == `VIPC_OFF_CTRL_B) begin
                ctrl_b <= i_pwdata[15:0];
            end
            for (int r = 0; r < 5; r++) begin
                if (i_paddr == `VIPC_OFF_EN0 + 12'(r * 4)) begin
                    enables[16*r +: 16] <= i_pwdata[15:0];
                end
            end
            for (int r = 0; r < 18; r++) begin
                if (i_paddr == `VIPC_OFF_PRIO0 + 12'(r * 4)) begin
                    prios[16*r +: 16] <= i_pwdata[15:0];
                end
            end
        end
    end

    // ----------------------------------------
    // APB read mux, zero wait, error on unmapped
    // ----------------------------------------
    always_comb begin
        hit = 1'b1;
        o_prdata = 32'h0;
        if (in_range(i_paddr, `VIPC_OFF_FLAG0, 5)) begin
            o_prdata = {16'h0, flags[16*(word - 5'd2) +: 16]};
        end else if (in_range(i_paddr, `VIPC_OFF_EN0, 5)) begin
            o_prdata = {16'h0, enables[16*(word - 5'd7) +: 16]};
        end else if (in_range(i_paddr, `VIPC_OFF_PRIO0, 18)) begin
            o_prdata = {16'h0, prios[16*(word - 5'd12) +: 16]};
        end else begin
            case (i_paddr)
                `VIPC_OFF_CTRL_A:  o_prdata = {16'h0, ctrl_a};
                `VIPC_OFF_CTRL_B:  o_prdata = {16'h0, ctrl_b};
                `VIPC_OFF_PENDING: o_prdata = {20'h0, pend_lvl, 1'b0, pend_vec};
                `VIPC_OFF_STATUS:  o_prdata = {24'h0, lvl_field, 5'h00};
                `VIPC_OFF_CORECTL: o_prdata = {28'h0, lvl_top, 3'h0};
                `VIPC_OFF_TRAPREQ: o_prdata = {24'h0, trap_pend};
                default:           hit = 1'b0;
            endcase
        end
        if (i_paddr[1:0] != 2'b00) begin
            hit      = 1'b0;
            o_prdata = 32'h0;
        end
    end
    assign o_pslverr = i_psel && i_penable && !hit;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_vec_user;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (state == VIPC_IDLE && !trap_any && arb_valid && !lvl_top)
            |=> (pend_vec == $past(arb_idx) + 7'h08);
    endproperty
    a_vec_user: assert property (p_vec_user) else $error("vector offset wrong");

    property p_lvl_match;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (state == VIPC_IDLE && !trap_any && arb_valid && !lvl_top)
            |=> (pend_lvl == {1'b0, $past(arb_prio)});
    endproperty
    a_lvl_match: assert property (p_lvl_match) else $error("pending level wrong");

    property p_above;
        @(posedge I_CLK) disable iff (!I_RST_B)
        arb_valid |-> ({1'b0, arb_prio} > cpu_level);
    endproperty
    a_above: assert property (p_above) else $error("source not above level");

    property p_flag_sticky;
        @(posedge I_CLK) disable iff (!I_RST_B)
        i_src_event[0] |=> flags[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_field_lock;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (ctrl_a[`VIPC_NEST_DIS_BIT] && state != VIPC_PRESENT && !i_irq_return)
            |=> $stable(lvl_field);
    endproperty
    a_field_lock: assert property (p_field_lock) else $error("field changed");

    property p_alt;
        @(posedge I_CLK) disable iff (!I_RST_B)
        ctrl_b[`VIPC_ALT_SEL_BIT] |-> o_vec_addr[8];
    endproperty
    a_alt: assert property (p_alt) else $error("alternate table unused");

    property p_no_nest;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (state == VIPC_SERVICE && ctrl_a[`VIPC_NEST_DIS_BIT] && !i_irq_return)
            |=> state == VIPC_SERVICE;
    endproperty
    a_no_nest: assert property (p_no_nest) else $error("nested while disabled");

    property p_top_mask;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (lvl_top && state == VIPC_SERVICE && !i_irq_return) |=> !o_irq_req;
    endproperty
    a_top_mask: assert property (p_top_mask) else $error("user irq above top");
endmodule
`default_nettype wire

/* File: vipc_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Processor core taking vectors
// ----------------------------------------
module vipc_core_model #(
    parameter int ACK_DELAY = 2
) (
    input  wire logic I_CLK,
    input  wire logic I_RST_B,
    input  wire logic i_irq_req,
    input  wire logic i_ack_en,
    input  wire logic i_do_return,
    output logic      o_ack,
    output logic      o_return
);
    int   wait_cnt;
    logic in_service;

    // Stall a while, then take the vector with a one-cycle pulse
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B || !i_irq_req || o_ack) begin
            wait_cnt <= 0;
            o_ack    <= 1'h0;
        end else if (i_ack_en && wait_cnt >= ACK_DELAY) begin
            o_ack <= 1'h1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    // Leave service once; never return when nothing was taken
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            in_service <= 1'h0;
            o_return   <= 1'h0;
        end else begin
            o_return <= i_do_return && in_service && !o_return;
            if (o_ack) begin
                in_service <= 1'h1;
            end else if (o_return) begin
                in_service <= 1'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "vipc_map.svh"
module tb;
    import vipc_pkg::*;
    logic        I_CLK;
    logic        I_RST_B;
    logic        psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [71:0] src;
    logic [7:0]  trap;
    logic        ack, ret, ack_en, do_ret, irq_req;
    logic [6:0]  vec_num;
    logic [23:0] vec_addr;
    vipc_level_t cpu_level;
    int          errors, samples_checked;
    int          srcs[7] = '{0, 13, 30, 46, 59, 64, 71};

    vipc_top #(.N_SRC(72)) dut (
        .I_CLK(I_CLK), .I_RST_B(I_RST_B), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_src_event(src), .i_trap_event(trap),
        .i_irq_ack(ack), .i_irq_return(ret), .o_irq_req(irq_req), .o_vec_num(vec_num),
        .o_vec_addr(vec_addr), .o_cpu_level(cpu_level)
    );
    vipc_core_model #(.ACK_DELAY(3)) core (
        .I_CLK(I_CLK), .I_RST_B(I_RST_B), .i_irq_req(irq_req), .i_ack_en(ack_en),
        .i_do_return(do_ret), .o_ack(ack), .o_return(ret)
    );

    always #5 I_CLK = ~I_CLK;

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            errors++;
        end
    endtask

    task give_up(input int k);
        if (k >= 50) begin
            errors++;
            wrap_up();
        end
    endtask

    // ----------------------------------------
    // APB master and core-side helpers
    // ----------------------------------------
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge I_CLK);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge I_CLK);
        penable <= 1'h1;
        @(posedge I_CLK);
        while (pready !== 1'h1 && k < 50) begin
            @(posedge I_CLK);
            k++;
        end
        rd = prdata;
        serr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        give_up(k);
    endtask

    // One-cycle event pulse on user and trap inputs
    task pulse(input logic [71:0] s, input logic [7:0] t);
        @(posedge I_CLK);
        src  <= s;
        trap <= t;
        @(posedge I_CLK);
        src  <= 72'h0;
        trap <= 8'h0;
    endtask

    task wait_req(input logic [6:0] v, input logic [23:0] a);
        int k;
        k = 0;
        @(posedge I_CLK);
        while (irq_req !== 1'h1 && k < 50) begin
            @(posedge I_CLK);
            k++;
        end
        give_up(k);
        check(32'(vec_num), 32'(v));
        check(32'(vec_addr), 32'(a));
    endtask

    // Let the core take the vector, then compare the new level
    task take(input logic [3:0] l);
        int k;
        k = 0;
        @(posedge I_CLK);
        ack_en <= 1'h1;
        while (irq_req !== 1'h0 && k < 50) begin
            @(posedge I_CLK);
            k++;
        end
        ack_en <= 1'h0;
        give_up(k);
        check(32'(cpu_level), 32'(l));
    endtask

    task leave();
        int k;
        k = 0;
        @(posedge I_CLK);
        do_ret <= 1'h1;
        @(posedge I_CLK);
        do_ret <= 1'h0;
        while (cpu_level !== 4'h0 && k < 50) begin
            @(posedge I_CLK);
            k++;
        end
        give_up(k);
    endtask

    // Full user vector round trip for request n at priority p
    task serve(input int n, input logic [2:0] p);
        apb(1'h1, 12'(`VIPC_OFF_EN0 + 4 * (n / 16)), 32'h1 << (n % 16));
        apb(1'h1, 12'(`VIPC_OFF_PRIO0 + 4 * (n / 4)), 32'(p) << (4 * (n % 4)));
        pulse(72'h1 << n, 8'h0);
        wait_req(7'(n + 8), 24'(4 + 2 * (n + 8)));
        apb(1'h0, `VIPC_OFF_PENDING, 32'h0);
        check(rd, (32'(p) << 8) | 32'(n + 8));
        take({1'h0, p});
        apb(1'h1, 12'(`VIPC_OFF_FLAG0 + 4 * (n / 16)), ~(32'h1 << (n % 16)));
        apb(1'h0, 12'(`VIPC_OFF_FLAG0 + 4 * (n / 16)), 32'h0);
        check(rd, 32'h0);
        leave();
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {I_CLK, psel, penable, pwrite, ack_en, do_ret} = 6'h0;
        {paddr, pwdata, src, trap} = '0;
        {errors, samples_checked} = '0;
        I_RST_B = 1'h0;
        repeat (6) @(posedge I_CLK);
        I_RST_B <= 1'h1;
        check(32'(cpu_level), 32'h0);
        apb(1'h0, `VIPC_OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, 12'h100, 32'h0);
        check(32'(serr), 32'h1);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            serve(srcs[i], 3'(i + 1));
        end
        $display("test vectors done");
        // Higher priority wins, equal priority goes to lower request
        apb(1'h1, `VIPC_OFF_EN0, 32'h0026);
        apb(1'h1, `VIPC_OFF_PRIO0, 32'h0630);
        apb(1'h1, 12'(`VIPC_OFF_PRIO0 + 4), 32'h0060);
        pulse(72'h26, 8'h0);
        wait_req(7'h0a, 24'h000018);
        take(4'h6);
        apb(1'h1, `VIPC_OFF_FLAG0, 32'hfffb);
        apb(1'h0, `VIPC_OFF_FLAG0, 32'h0);
        check(rd, 32'h0022);
        leave();
        wait_req(7'h0d, 24'h00001e);
        take(4'h6);
        apb(1'h1, `VIPC_OFF_FLAG0, 32'hffdd);
        leave();
        $display("test arbitration done");
        // CPU level masks sources at or below it; disabled source stays quiet
        apb(1'h1, `VIPC_OFF_STATUS, 32'h00a0);
        apb(1'h0, `VIPC_OFF_STATUS, 32'h0);
        check(rd, 32'h00a0);
        check(32'(cpu_level), 32'h5);
        apb(1'h1, `VIPC_OFF_EN0, 32'h0001);
        apb(1'h1, `VIPC_OFF_PRIO0, 32'h0005);
        pulse(72'h9, 8'h0);
        repeat (5) @(posedge I_CLK);
        check(32'(irq_req), 32'h0);
        apb(1'h0, `VIPC_OFF_FLAG0, 32'h0);
        check(rd, 32'h0009);
        apb(1'h1, `VIPC_OFF_STATUS, 32'h0080);
        wait_req(7'h08, 24'h000014);
        take(4'h5);
        apb(1'h1, `VIPC_OFF_FLAG0, 32'hfff6);
        leave();
        $display("test masking done");
        // Nesting off: no second vector in service, level field frozen
        apb(1'h1, `VIPC_OFF_CTRL_A, 32'h8000);
        apb(1'h0, `VIPC_OFF_CTRL_A, 32'h0);
        check(rd, 32'h8000);
        apb(1'h1, `VIPC_OFF_EN0, 32'h0003);
        apb(1'h1, `VIPC_OFF_PRIO0, 32'h0062);
        pulse(72'h1, 8'h0);
        wait_req(7'h08, 24'h000014);
        take(4'h2);
        pulse(72'h2, 8'h0);
        repeat (5) @(posedge I_CLK);
        check(32'(irq_req), 32'h0);
        apb(1'h1, `VIPC_OFF_STATUS, 32'h0);
        apb(1'h0, `VIPC_OFF_STATUS, 32'h0);
        check(rd, 32'h0040);
        apb(1'h1, `VIPC_OFF_FLAG0, 32'hfffe);
        leave();
        wait_req(7'h09, 24'h000016);
        take(4'h6);
        apb(1'h1, `VIPC_OFF_FLAG0, 32'hfffd);
        apb(1'h1, `VIPC_OFF_CTRL_A, 32'h0);
        leave();
        $display("test nesting done");
        // Traps through the alternate table, top level bit read-only
        apb(1'h1, `VIPC_OFF_CTRL_B, 32'h8000);
        apb(1'h0, `VIPC_OFF_CTRL_B, 32'h0);
        check(rd, 32'h8000);
        for (int t = 1; t < 6; t++) begin
            pulse(72'h0, 8'h1 << t);
            wait_req(7'(t), 24'h000104 + 24'(2 * t));
            take(4'hf);
            apb(1'h1, `VIPC_OFF_CORECTL, 32'h0);
            apb(1'h0, `VIPC_OFF_CORECTL, 32'h0);
            check(rd, 32'h0008);
            leave();
        end
        $display("test traps done");
        wrap_up();
    end
endmodule
`default_nettype wire
